// ===== fac_ctrl.sv
// Flash array controller: APB registers, debugger port, program and erase sequencer
`timescale 1ns/1ps
`include "fac_map.svh"

//Functional notes
// - 512-byte page is smallest erase unit
// - Each page holds 8 rows of 64
// - Sectors 1024 bytes on 8K, else 512
// - Capacity 8K/4K/2K/1K from address zero
// - Two lowest bytes hold option bits
// - CPU or debugger may program and erase
// - Frequency kHz value times program and erase
// - Read protect blocks debugger reading code
// - Two option bits give three levels
// - Options, lock, page check, sectors all required; only CPU program and page erase check all four
module fac_ctrl (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [1:0] variant_pin,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input fac_pkg::fac_dbg_req_type dbg_req,
	output fac_pkg::fac_dbg_rsp_type dbg_rsp,
	output logic busy
);
	import fac_pkg::*;

	// ********************************
	// Helpers
	// ********************************
	function automatic logic [31:0] fac_cycles(input logic [15:0] khz, input logic [31:0] us);
		logic [47:0] prod;
		logic [47:0] quot;
		prod = {32'h0, khz} * {16'h0, us};
		quot = prod / `FAC_KHZ_PER_MHZ;
		fac_cycles = (quot == 48'h0) ? 32'h1 : quot[31:0];
	endfunction : fac_cycles

	function automatic logic fac_in_range(input logic [12:0] a, input logic [1:0] v);
		fac_in_range = a <= (`FAC_ADDR_LAST >> v);
	endfunction : fac_in_range

	function automatic logic [2:0] fac_sector(input logic [12:0] a, input logic [1:0] v);
		fac_sector = (v == 2'd0) ? a[12:10] : a[11:9];
	endfunction : fac_sector

	// ********************************
	// State
	// ********************************
	fac_state_type state;
	fac_lock_type lock_state;
	fac_level_type level;
	logic [1:0] variant_s1, variant_s2, variant_s3, variant;
	logic [7:0] freq_hi, freq_lo, opt_byte0, opt_byte1, sect_prot;
	logic [15:0] prog_clock_khz;
	logic [3:0] page_sel, page_chk;
	logic [12:0] addr_reg, op_addr, op_end, mem_addr;
	logic [7:0] op_data, mem_wdata, mem_rdata;
	logic op_mass, op_dbg, rd_dbg, refused_flag, mem_we;
	logic [31:0] wait_cnt;
	logic read_protect_option, write_protect_option;
	logic wr, ctrl_wr, erase_req, mass_req, prog_req, page_ok;
	logic erase_ok, mass_ok, prog_ok, apb_data_rd, apb_rd_start, apb_start;
	logic dbg_take, dbg_read_ok, dbg_prog_ok, dbg_refuse;
	logic [12:0] erase_base;

	// Variant straps pass three stages; a change counts once the last two agree
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			variant_s1 <= 2'h0;
			variant_s2 <= 2'h0;
			variant_s3 <= 2'h0;
		end else begin
			variant_s1 <= variant_pin;
			variant_s2 <= variant_s1;
			variant_s3 <= variant_s2;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			variant <= 2'h0;
		end else if (variant_s2 == variant_s3) begin
			variant <= variant_s3;
		end
	end

	assign prog_clock_khz = {freq_hi, freq_lo};
	// Programmed option bits read as zero
	assign read_protect_option = ~opt_byte0[`FAC_OPT_RP_BIT];
	assign write_protect_option = ~opt_byte0[`FAC_OPT_WP_BIT];

	always_comb begin
		if (write_protect_option) begin
			level = FAC_WRITE_LOCKED;
		end else if (read_protect_option) begin
			level = FAC_READ_LOCKED;
		end else begin
			level = FAC_OPEN;
		end
	end

	// ********************************
	// Request decode
	// ********************************
	assign wr = psel & penable & pwrite;
	assign ctrl_wr = wr & (paddr == `FAC_OFS_CTRL);
	assign erase_req = ctrl_wr & (lock_state == FAC_UNLOCKED)
		& (pwdata[7:0] == `FAC_CMD_PAGE_ERASE);
	assign mass_req = ctrl_wr & (lock_state == FAC_UNLOCKED)
		& (pwdata[7:0] == `FAC_CMD_MASS_ERASE);
	assign prog_req = wr & (paddr == `FAC_OFS_DATA) & (lock_state == FAC_UNLOCKED);
	assign page_ok = page_chk == ~page_sel;
	assign erase_base = {page_sel, 9'h0};
	assign erase_ok = (state == FAC_IDLE) & (level != FAC_WRITE_LOCKED) & page_ok
		& fac_in_range(erase_base, variant) & ~sect_prot[fac_sector(erase_base, variant)];
	assign mass_ok = (state == FAC_IDLE) & (level != FAC_WRITE_LOCKED) & (sect_prot == 8'h0);
	assign prog_ok = (state == FAC_IDLE) & (level != FAC_WRITE_LOCKED) & page_ok
		& (addr_reg[12:9] == page_sel) & fac_in_range(addr_reg, variant)
		& ~sect_prot[fac_sector(addr_reg, variant)];
	assign apb_data_rd = psel & penable & ~pwrite & (paddr == `FAC_OFS_DATA);
	assign apb_rd_start = apb_data_rd & (state == FAC_IDLE);
	assign apb_start = (erase_req & erase_ok) | (mass_req & mass_ok) | (prog_req & prog_ok);

	assign dbg_take = dbg_req.valid & ~dbg_rsp.ack & (state == FAC_IDLE)
		& ~apb_start & ~apb_rd_start;
	assign dbg_read_ok = ~read_protect_option & fac_in_range(dbg_req.addr, variant);
	assign dbg_prog_ok = (level == FAC_OPEN) & fac_in_range(dbg_req.addr, variant)
		& ~sect_prot[fac_sector(dbg_req.addr, variant)];
	assign dbg_refuse = dbg_take & (((dbg_req.cmd == FAC_DBG_READ) & ~dbg_read_ok)
		| ((dbg_req.cmd == FAC_DBG_PROGRAM) & ~dbg_prog_ok));

	// ********************************
	// APB slave
	// ********************************
	// Only array reads stall: the data arrives one cycle after the lookup
	assign pready = ~apb_data_rd | ((state == FAC_READ) & ~rd_dbg);
	assign busy = state != FAC_IDLE;

	always_comb begin
		prdata = 32'h0;
		pslverr = 1'b0;
		unique case (paddr)
			`FAC_OFS_FREQ_HI: prdata = {24'h0, freq_hi};
			`FAC_OFS_FREQ_LO: prdata = {24'h0, freq_lo};
			`FAC_OFS_CTRL: prdata = 32'h0;
			`FAC_OFS_PAGE: prdata = {28'h0, page_sel};
			`FAC_OFS_PAGE_CHK: prdata = {28'h0, page_chk};
			`FAC_OFS_SECT_PROT: prdata = {24'h0, sect_prot};
			`FAC_OFS_ADDR: prdata = {19'h0, addr_reg};
			`FAC_OFS_DATA: prdata = {24'h0, mem_rdata};
			`FAC_OFS_STATUS: prdata = {27'h0, level == FAC_WRITE_LOCKED, read_protect_option,
				lock_state == FAC_UNLOCKED, refused_flag, busy};
			`FAC_OFS_OPTION: prdata = {16'h0, opt_byte1, opt_byte0};
			default: pslverr = psel & penable;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			freq_hi <= 8'h0;
			freq_lo <= 8'h0;
			page_sel <= 4'h0;
			page_chk <= 4'h0;
			addr_reg <= 13'h0;
		end else if (wr) begin
			if (paddr == `FAC_OFS_FREQ_HI) freq_hi <= pwdata[7:0];
			if (paddr == `FAC_OFS_FREQ_LO) freq_lo <= pwdata[7:0];
			if (paddr == `FAC_OFS_PAGE) page_sel <= pwdata[3:0];
			if (paddr == `FAC_OFS_PAGE_CHK) page_chk <= pwdata[3:0];
			if (paddr == `FAC_OFS_ADDR) addr_reg <= pwdata[12:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sect_prot <= 8'h0;
		end else if (wr && paddr == `FAC_OFS_SECT_PROT) begin
			sect_prot <= sect_prot | pwdata[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			lock_state <= FAC_LOCKED;
		end else if (ctrl_wr) begin
			if (lock_state == FAC_LOCKED && pwdata[7:0] == `FAC_KEY_FIRST) begin
				lock_state <= FAC_KEY_SEEN;
			end else if (lock_state == FAC_KEY_SEEN && pwdata[7:0] == `FAC_KEY_SECOND) begin
				lock_state <= FAC_UNLOCKED;
			end else begin
				lock_state <= FAC_LOCKED;
			end
		end
	end

	// Set wins over the write-one clear
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			refused_flag <= 1'b0;
		end else if ((erase_req & ~erase_ok) | (mass_req & ~mass_ok) | (prog_req & ~prog_ok)) begin
			refused_flag <= 1'b1;
		end else if (wr && paddr == `FAC_OFS_STATUS && pwdata[`FAC_STAT_REFUSED]) begin
			refused_flag <= 1'b0;
		end
	end

	// ********************************
	// Sequencer
	// ********************************
	always_comb begin
		mem_addr = op_addr;
		mem_we = 1'b0;
		mem_wdata = op_data;
		unique case (state)
			FAC_LOAD0: mem_addr = 13'h0;
			FAC_LOAD1: mem_addr = 13'h1;
			FAC_IDLE: mem_addr = apb_rd_start ? addr_reg : dbg_req.addr;
			FAC_FILL: begin
				mem_we = 1'b1;
				mem_wdata = `FAC_ERASED;
			end
			FAC_PROG: mem_we = 1'b1;
			FAC_LOAD2, FAC_WAIT, FAC_READ: mem_we = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= FAC_LOAD0;
			op_addr <= 13'h0;
			op_end <= 13'h0;
			op_data <= 8'h0;
			op_mass <= 1'b0;
			op_dbg <= 1'b0;
			rd_dbg <= 1'b0;
			wait_cnt <= 32'h0;
		end else begin
			unique case (state)
				FAC_LOAD0: state <= FAC_LOAD1;
				FAC_LOAD1: state <= FAC_LOAD2;
				FAC_LOAD2: state <= FAC_IDLE;
				FAC_IDLE: begin
					op_dbg <= dbg_take;
					if (erase_req & erase_ok) begin
						op_addr <= erase_base;
						op_end <= {page_sel, `FAC_PAGE_LAST_OFS};
						op_mass <= 1'b0;
						state <= FAC_FILL;
					end else if ((mass_req & mass_ok)
						| (dbg_take & ~dbg_refuse & dbg_req.cmd == FAC_DBG_MASS_ERASE)) begin
						op_addr <= 13'h0;
						op_end <= `FAC_ADDR_LAST >> variant;
						op_mass <= 1'b1;
						state <= FAC_FILL;
					end else if (prog_req & prog_ok) begin
						op_addr <= addr_reg;
						op_data <= pwdata[7:0];
						state <= FAC_PROG;
					end else if (dbg_take & ~dbg_refuse & dbg_req.cmd == FAC_DBG_PROGRAM) begin
						op_addr <= dbg_req.addr;
						op_data <= dbg_req.wdata;
						state <= FAC_PROG;
					end else if (apb_rd_start | (dbg_take & ~dbg_refuse)) begin
						rd_dbg <= ~apb_rd_start;
						state <= FAC_READ;
					end
				end
				FAC_FILL: begin
					op_addr <= op_addr + 13'h1;
					if (op_addr == op_end) begin
						wait_cnt <= fac_cycles(prog_clock_khz,
							op_mass ? `FAC_MASS_TIME_US : `FAC_ERASE_TIME_US);
						state <= FAC_WAIT;
					end
				end
				FAC_PROG: begin
					wait_cnt <= fac_cycles(prog_clock_khz, `FAC_PROG_TIME_US);
					state <= FAC_WAIT;
				end
				FAC_WAIT: begin
					wait_cnt <= wait_cnt - 32'h1;
					if (wait_cnt <= 32'h1) begin
						// Mass erase wipes the options, so they are read again
						state <= op_mass ? FAC_LOAD0 : FAC_IDLE;
						op_mass <= 1'b0;
					end
				end
				FAC_READ: begin
					rd_dbg <= 1'b0;
					state <= FAC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			opt_byte0 <= `FAC_OPT_RESET;
			opt_byte1 <= `FAC_OPT_RESET;
		end else begin
			if (state == FAC_LOAD1) opt_byte0 <= mem_rdata;
			if (state == FAC_LOAD2) opt_byte1 <= mem_rdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dbg_rsp <= '0;
		end else begin
			dbg_rsp.ack <= (dbg_take & (dbg_refuse | dbg_req.cmd != FAC_DBG_READ))
				| (state == FAC_READ & rd_dbg);
			dbg_rsp.refused <= dbg_refuse;
			dbg_rsp.rdata <= (state == FAC_READ & rd_dbg) ? mem_rdata : 8'h0;
		end
	end

	fac_mem u_mem (
		.ref_clk(ref_clk),
		.addr(mem_addr),
		.write_en(mem_we),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	logic [12:0] fill_len;
	always_ff @(posedge ref_clk) begin
		if (reset || state != FAC_FILL) fill_len <= 13'h0;
		else fill_len <= fill_len + 13'h1;
	end

	sequence s_load_tail;
		##1 state == FAC_LOAD1 ##1 state == FAC_LOAD2 ##1 state == FAC_IDLE;
	endsequence

	AST_PAGE_FILL_LEN: assert property (
		(state == FAC_FILL && !op_mass && op_addr == op_end) |-> fill_len == 13'd511)
		else $error("page erase did not cover 512 bytes");
	AST_ROW_STEP: assert property (
		(state == FAC_FILL && op_addr[5:0] == `FAC_ROW_LAST_OFS && op_addr != op_end)
		|=> op_addr[5:0] == 6'h0 && op_addr[12:6] == $past(op_addr[12:6]) + 7'h1)
		else $error("row boundary not crossed correctly");
	AST_SECTOR_REFUSE: assert property (
		(erase_req && sect_prot[fac_sector(erase_base, variant)]) |=> refused_flag
		&& state == FAC_IDLE) else $error("protected sector erased");
	AST_RANGE_REFUSE: assert property (
		(prog_req && !fac_in_range(addr_reg, variant)) |=> state != FAC_PROG && refused_flag)
		else $error("program outside fitted array");
	AST_OPTION_LOAD: assert property (
		state == FAC_LOAD0 |-> s_load_tail) else $error("option load sequence broken");
	AST_PROG_TIME: assert property (
		state == FAC_PROG |=> state == FAC_WAIT
		&& wait_cnt == fac_cycles(prog_clock_khz, `FAC_PROG_TIME_US))
		else $error("program time not from frequency value");
	AST_DBG_READ_BLOCK: assert property (
		(dbg_take && dbg_req.cmd == FAC_DBG_READ && read_protect_option)
		|=> dbg_rsp.ack && dbg_rsp.refused && dbg_rsp.rdata == 8'h0 && state == FAC_IDLE)
		else $error("protected code returned to debugger");
	AST_LEVELS: assert property (
		(write_protect_option |-> level == FAC_WRITE_LOCKED)
		and ((read_protect_option && !write_protect_option) |-> level == FAC_READ_LOCKED))
		else $error("protection level mismatch");
	AST_USER_PROG_UNLOCKED: assert property (
		(state == FAC_PROG && !op_dbg) |-> $past(lock_state) == FAC_UNLOCKED
		&& $past(page_chk) == ~$past(page_sel)) else $error("program without unlock");
	AST_FILL_PAGE: assert property (
		(state == FAC_FILL && !op_mass) |-> op_addr[12:9] == op_end[12:9])
		else $error("erase left its page");

endmodule : fac_ctrl

// ===== fac_dbg_host.sv
// Debugger-side requester model for the flash array controller
`timescale 1ns/1ps
module fac_dbg_host (
	input wire logic ref_clk,
	input fac_pkg::fac_dbg_rsp_type dbg_rsp,
	output fac_pkg::fac_dbg_req_type dbg_req
);
	import fac_pkg::*;

	initial dbg_req = '0;

	// ********************************
	// Single byte transfer
	// ********************************
	// debugger issues requests
	task xfer(input fac_dbg_cmd_type c, input logic [12:0] a, input logic [7:0] d,
		output logic ok, output fac_dbg_rsp_type r);
		int i;
		ok = 1'b0;
		r = '0;
		@(posedge ref_clk);
		dbg_req <= '{1'b1, c, a, d};
		for (i = 0; i < 400 && !ok; i++) begin
			@(posedge ref_clk);
			if (dbg_rsp.ack === 1'b1) begin
				ok = 1'b1;
				r = dbg_rsp;
			end
		end
		// Released at the ack edge; address and data lines show the inverse so a stale value never looks held
		dbg_req <= '{1'b0, c, ~a, ~d};
	endtask : xfer

endmodule : fac_dbg_host

// ===== fac_map.svh
// Register offsets, command codes, geometry and timing constants of the flash array controller
`ifndef FAC_MAP_SVH
`define FAC_MAP_SVH

// ********************************
// Register offsets (byte addresses)
// ********************************
`define FAC_OFS_FREQ_HI 8'h00
`define FAC_OFS_FREQ_LO 8'h04
`define FAC_OFS_CTRL 8'h08
`define FAC_OFS_PAGE 8'h0c
`define FAC_OFS_PAGE_CHK 8'h10
`define FAC_OFS_SECT_PROT 8'h14
`define FAC_OFS_ADDR 8'h18
`define FAC_OFS_DATA 8'h1c
`define FAC_OFS_STATUS 8'h20
`define FAC_OFS_OPTION 8'h24

// ********************************
// Control codes and field positions
// ********************************
`define FAC_KEY_FIRST 8'h73
`define FAC_KEY_SECOND 8'h8c
`define FAC_CMD_PAGE_ERASE 8'h95
`define FAC_CMD_MASS_ERASE 8'h63
`define FAC_STAT_BUSY 0
`define FAC_STAT_REFUSED 1
`define FAC_STAT_UNLOCKED 2
`define FAC_OPT_RP_BIT 7
`define FAC_OPT_WP_BIT 6

// ********************************
// Geometry and reset values
// ********************************
`define FAC_ARRAY_BYTES 8192
`define FAC_ADDR_LAST 13'h1fff
`define FAC_PAGE_LAST_OFS 9'h1ff
`define FAC_ROW_LAST_OFS 6'h3f
`define FAC_ERASED 8'hff
`define FAC_OPT_RESET 8'hff

// ********************************
// Timing, in microseconds of the programmed clock
// ********************************
`define FAC_PROG_TIME_US 32'd40
`define FAC_ERASE_TIME_US 32'd10000
`define FAC_MASS_TIME_US 32'd20000
`define FAC_KHZ_PER_MHZ 48'd1000

`endif

// ===== fac_mem.sv
// Byte-wide array storage with a registered read port
`timescale 1ns/1ps
`include "fac_map.svh"

module fac_mem (
	input wire logic ref_clk,
	input wire logic [12:0] addr,
	input wire logic write_en,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	import fac_pkg::*;

	logic [7:0] cells [0:`FAC_ARRAY_BYTES-1];

	// Starts erased so the option bytes read as unprogrammed
	initial begin
		for (int i = 0; i < `FAC_ARRAY_BYTES; i++) begin
			cells[i] = `FAC_ERASED;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (write_en) begin
			cells[addr] <= wdata;
		end
		rdata <= cells[addr];
	end

endmodule : fac_mem

// ===== fac_pkg.sv
// Types shared by the flash array controller files
package fac_pkg;

	typedef enum logic [1:0] {
		FAC_DBG_READ,
		FAC_DBG_PROGRAM,
		FAC_DBG_MASS_ERASE
	} fac_dbg_cmd_type;

	typedef enum {
		FAC_LOAD0,
		FAC_LOAD1,
		FAC_LOAD2,
		FAC_IDLE,
		FAC_FILL,
		FAC_PROG,
		FAC_WAIT,
		FAC_READ
	} fac_state_type;

	typedef enum {FAC_OPEN, FAC_READ_LOCKED, FAC_WRITE_LOCKED} fac_level_type;

	typedef enum {FAC_LOCKED, FAC_KEY_SEEN, FAC_UNLOCKED} fac_lock_type;

	typedef struct packed {
		logic valid;
		fac_dbg_cmd_type cmd;
		logic [12:0] addr;
		logic [7:0] wdata;
	} fac_dbg_req_type;

	typedef struct packed {
		logic ack;
		logic refused;
		logic [7:0] rdata;
	} fac_dbg_rsp_type;

endpackage : fac_pkg

// ===== tb.sv
// Self-checking bench for the flash array controller
`timescale 1ns/1ps
`include "fac_map.svh"
module tb;
	import fac_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [1:0] variant_pin = 2'h0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic busy;
	fac_dbg_req_type dbg_req;
	fac_dbg_rsp_type dbg_rsp;
	int n_errors = 0;
	int comparisons = 0;
	int n;
	logic [31:0] rd;
	logic err;
	logic refused;

	always #5 ref_clk = ~ref_clk;

	fac_ctrl DUT (
		.ref_clk(ref_clk),
		.reset(reset),
		.variant_pin(variant_pin),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.dbg_req(dbg_req),
		.dbg_rsp(dbg_rsp),
		.busy(busy)
	);

	fac_dbg_host host (.ref_clk(ref_clk), .dbg_rsp(dbg_rsp), .dbg_req(dbg_req));

	// ********************************
	// Helpers
	// ********************************
	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task fail(input string what);
		n_errors++;
		$display("wrong value %s expected completion seen timeout", what);
		end_of_test();
	endtask : fail

	// Waits are bounded so a stuck slave ends the run instead of hanging it
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		i = 0;
		// Answer taken at the rising edge that ends the access, then released
		do begin
			@(posedge ref_clk);
			i++;
		end while (pready !== 1'b1 && i < 30000);
		if (i >= 30000) fail("pready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check("register", rd & m, exp);
	endtask : rdchk

	task wait_idle(output int c);
		c = 0;
		do begin
			@(negedge ref_clk);
			c++;
		end while (busy !== 1'b0 && c < 30000);
		if (c >= 30000) fail("busy");
	endtask : wait_idle

	task attempt(input logic [3:0] pg, input logic [3:0] ck, input logic [12:0] a,
		input logic key, input logic er, input logic [7:0] d);
		wr(`FAC_OFS_PAGE, {28'h0, pg});
		wr(`FAC_OFS_PAGE_CHK, {28'h0, ck});
		wr(`FAC_OFS_ADDR, {19'h0, a});
		wr(`FAC_OFS_CTRL, 32'h0);
		if (key) begin
			wr(`FAC_OFS_CTRL, {24'h0, `FAC_KEY_FIRST});
			wr(`FAC_OFS_CTRL, {24'h0, `FAC_KEY_SECOND});
		end
		if (er) wr(`FAC_OFS_CTRL, {24'h0, `FAC_CMD_PAGE_ERASE});
		else wr(`FAC_OFS_DATA, {24'h0, d});
		wait_idle(n);
		apb(1'b0, `FAC_OFS_STATUS, 32'h0);
		refused = rd[`FAC_STAT_REFUSED];
		wr(`FAC_OFS_STATUS, 32'h2);
	endtask : attempt

	task flag(input logic e);
		check("refused", {31'h0, refused}, {31'h0, e});
	endtask : flag

	task prog(input logic [12:0] a, input logic [7:0] d);
		attempt(a[12:9], ~a[12:9], a, 1'b1, 1'b0, d);
		flag(1'b0);
	endtask : prog

	task rdarr(input logic [12:0] a, input logic [7:0] exp);
		wr(`FAC_OFS_ADDR, {19'h0, a});
		apb(1'b0, `FAC_OFS_DATA, 32'h0);
		check("array byte", rd, {24'h0, exp});
	endtask : rdarr

	task dbg(input fac_dbg_cmd_type c, input logic [12:0] a, input logic [7:0] d,
		input logic rf, input logic [7:0] exp);
		logic ok;
		fac_dbg_rsp_type r;
		host.xfer(c, a, d, ok, r);
		if (ok !== 1'b1) fail("dbg_rsp.ack");
		check("dbg refused", {31'h0, r.refused}, {31'h0, rf});
		check("dbg rdata", {24'h0, r.rdata}, {24'h0, exp});
	endtask : dbg

	task do_reset(input logic [15:0] khz);
		reset <= 1'b1;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		wait_idle(n);
		wr(`FAC_OFS_FREQ_HI, {24'h0, khz[15:8]});
		wr(`FAC_OFS_FREQ_LO, {24'h0, khz[7:0]});
	endtask : do_reset

	// ********************************
	// Scenarios
	// ********************************
	task t_reset;
		rdchk(`FAC_OFS_STATUS, 32'h1f, 32'h0);
		rdchk(`FAC_OFS_OPTION, 32'hffffffff, 32'h0000ffff);
		apb(1'b0, 8'h28, 32'h0);
		check("pslverr", {31'h0, err}, 32'h1);
		check("unmapped read", rd, 32'h0);
		$display("test reset done");
	endtask : t_reset

	task t_program;
		prog(13'h0205, 8'h5a);
		rdarr(13'h0205, 8'h5a);
		prog(13'h023f, 8'h11);
		prog(13'h0240, 8'h22);
		rdarr(13'h023f, 8'h11);
		rdarr(13'h0240, 8'h22);
		attempt(4'h1, 4'he, 13'h0405, 1'b1, 1'b0, 8'h33);
		flag(1'b1);
		attempt(4'h1, 4'h1, 13'h0206, 1'b1, 1'b0, 8'h33);
		flag(1'b1);
		attempt(4'h1, 4'he, 13'h0206, 1'b0, 1'b0, 8'h33);
		// Locked data writes are dropped without raising the refused flag
		flag(1'b0);
		rdarr(13'h0206, 8'hff);
		rdarr(13'h0405, 8'hff);
		$display("test program done");
	endtask : t_program

	task t_erase;
		prog(13'h03ff, 8'h44);
		prog(13'h0400, 8'h55);
		wr(`FAC_OFS_FREQ_LO, 32'h32);
		attempt(4'h1, 4'he, 13'h0000, 1'b1, 1'b1, 8'h00);
		flag(1'b0);
		// Fill of 512 plus 500 timed cycles at 50 kHz, small slack for edges
		check("erase cycles", {31'h0, (n > 1005 && n < 1020)}, 32'h1);
		wr(`FAC_OFS_FREQ_LO, 32'h1);
		rdarr(13'h0205, 8'hff);
		rdarr(13'h03ff, 8'hff);
		rdarr(13'h0400, 8'h55);
		attempt(4'h2, 4'h2, 13'h0000, 1'b1, 1'b1, 8'h00);
		flag(1'b1);
		rdarr(13'h0400, 8'h55);
		$display("test erase done");
	endtask : t_erase

	task t_sector;
		wr(`FAC_OFS_SECT_PROT, 32'h4);
		attempt(4'h5, 4'ha, 13'h0bff, 1'b1, 1'b0, 8'h33);
		flag(1'b1);
		attempt(4'h5, 4'ha, 13'h0a00, 1'b1, 1'b1, 8'h00);
		flag(1'b1);
		prog(13'h0c00, 8'h66);
		rdarr(13'h0c00, 8'h66);
		variant_pin <= 2'h1;
		repeat (8) @(posedge ref_clk);
		attempt(4'h2, 4'hd, 13'h0400, 1'b1, 1'b0, 8'h33);
		flag(1'b1);
		prog(13'h0600, 8'h67);
		rdarr(13'h0600, 8'h67);
		variant_pin <= 2'h3;
		repeat (8) @(posedge ref_clk);
		attempt(4'h3, 4'hc, 13'h0700, 1'b1, 1'b0, 8'h33);
		flag(1'b1);
		dbg(FAC_DBG_READ, 13'h0400, 8'h00, 1'b1, 8'h00);
		dbg(FAC_DBG_READ, 13'h03ff, 8'h00, 1'b0, 8'hff);
		variant_pin <= 2'h0;
		repeat (8) @(posedge ref_clk);
		$display("test sector done");
	endtask : t_sector

	task t_debug;
		dbg(FAC_DBG_PROGRAM, 13'h0700, 8'h77, 1'b0, 8'h00);
		rdarr(13'h0700, 8'h77);
		dbg(FAC_DBG_READ, 13'h0700, 8'h00, 1'b0, 8'h77);
		prog(13'h0000, 8'h7f);
		do_reset(16'h1);
		rdchk(`FAC_OFS_OPTION, 32'hffffffff, 32'h0000ff7f);
		rdchk(`FAC_OFS_STATUS, 32'h18, 32'h08);
		dbg(FAC_DBG_READ, 13'h0700, 8'h00, 1'b1, 8'h00);
		rdarr(13'h0700, 8'h77);
		dbg(FAC_DBG_PROGRAM, 13'h0702, 8'h55, 1'b1, 8'h00);
		dbg(FAC_DBG_MASS_ERASE, 13'h0000, 8'h00, 1'b0, 8'h00);
		wait_idle(n);
		rdchk(`FAC_OFS_STATUS, 32'h18, 32'h0);
		rdarr(13'h0700, 8'hff);
		prog(13'h0000, 8'hbf);
		do_reset(16'h1);
		rdchk(`FAC_OFS_STATUS, 32'h18, 32'h10);
		attempt(4'h3, 4'hc, 13'h0700, 1'b1, 1'b0, 8'h33);
		flag(1'b1);
		dbg(FAC_DBG_MASS_ERASE, 13'h0000, 8'h00, 1'b0, 8'h00);
		wait_idle(n);
		rdchk(`FAC_OFS_STATUS, 32'h18, 32'h0);
		$display("test debug done");
	endtask : t_debug

	initial begin
		do_reset(16'h1);
		t_reset();
		t_program();
		t_erase();
		t_sector();
		t_debug();
		end_of_test();
	end

endmodule : tb
